// file: testbench/mdfb_actuator.sv
// ------------------------------------------------------------
// far-side switching actuator: counts telegrams, holds lamp
// ------------------------------------------------------------
module mdfb_actuator
   import mdfb_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire mdfb_pkg::mdfb_out_t tg_i,
   output logic [7:0] n_on_o,
   output logic [7:0] n_off_o,
   output logic light_o
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         n_on_o <= 8'h00;
         n_off_o <= 8'h00;
         light_o <= 1'b0;
      end
      else
      begin
         // end wins so a stray overlap leaves the lamp dark
         if (tg_i.begin_tg)
         begin
            n_on_o <= n_on_o + 8'h01;
            light_o <= 1'b1;
         end
         if (tg_i.end_tg)
         begin
            n_off_o <= n_off_o + 8'h01;
            light_o <= 1'b0;
         end
      end
   end
endmodule : mdfb_actuator

// file: testbench/tb_mdfb_block.sv
module tb_mdfb_block;
   timeunit 1ns;
   timeprecision 100ps;
   import mdfb_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   mdfb_cfg_t cfg;
   logic mot = 1'b0;
   logic [15:0] bright = 16'h0080;
   logic teach = 1'b0;
   logic twl_wr = 1'b0;
   logic [15:0] twl = 16'h0000;
   logic man_on = 1'b0;
   logic man_off = 1'b0;
   logic ext_mot = 1'b0;
   logic ext_en = 1'b0;
   mdfb_out_t out1;
   logic out2_en;
   logic active;
   logic [7:0] n_on;
   logic [7:0] n_off;
   logic light;
   logic out2_en_b;
   int fails = 0;
   int checks = 0;
   always #12.5 clk_sys_i = ~clk_sys_i;
   mdfb_block #(.BLOCK_INDEX(1), .BASE_DELAY(20)) mdfb_block_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .cfg_i(cfg), .motion_i(mot), .ext_motion_i(ext_mot), .ext_enable_i(ext_en), .bright_i(bright),
      .teach_i(teach), .bus_twl_wr_i(twl_wr), .bus_twl_i(twl), .manual_on_i(man_on),
      .manual_off_i(man_off), .out1_o(out1), .out2_en_o(out2_en), .active_o(active));
   // second block position: the light control coupling must not take effect here
   mdfb_block #(.BLOCK_INDEX(2), .BASE_DELAY(20)) mdfb_block_fb2_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
      .cfg_i(cfg), .motion_i(mot), .ext_motion_i(ext_mot), .ext_enable_i(ext_en), .bright_i(bright),
      .teach_i(teach), .bus_twl_wr_i(twl_wr), .bus_twl_i(twl), .manual_on_i(man_on),
      .manual_off_i(man_off), .out1_o(), .out2_en_o(out2_en_b), .active_o());
   mdfb_actuator mdfb_actuator_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .tg_i(out1),
      .n_on_o(n_on), .n_off_o(n_off), .light_o(light));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task cnt(input string name, input logic [7:0] on, input logic [7:0] off);
      check({name, "_on"}, n_on, on);
      check({name, "_off"}, n_off, off);
   endtask : cnt
   task idle(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : idle
   task pulse(input int n);
      repeat (n)
      begin
         @(posedge clk_sys_i) mot <= 1'b1;
         @(posedge clk_sys_i) mot <= 1'b0;
      end
   endtask : pulse
   task xpulse(input int n);
      repeat (n)
      begin
         @(posedge clk_sys_i) ext_mot <= 1'b1;
         @(posedge clk_sys_i) ext_mot <= 1'b0;
      end
   endtask : xpulse
   task mode(input mdfb_app_t app, input logic indep);
      @(posedge clk_sys_i);
      cfg.app <= app;
      cfg.bright_indep <= indep;
   endtask : mode
   task done(input string name);
      $display("test %s finished", name);
   endtask : done
   task results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      #(25 * 4000);
      fails++;
      results();
   end
   initial
   begin
      cfg = '0;
      cfg.twilight_cfg = 16'h0100;
      cfg.switch_off = 16'h0300;
      cfg.eval_dly = 36'h00000000a;
      cfg.off_dly = 36'h000000005;
      cfg.alert_cnt = 8'h04;
      cfg.monitor = 36'h000000064;
      idle(8);
      rst_n_i <= 1'b1;
      mode(MDFB_APP_CEILING, 1'b0);
      pulse(1);
      idle(3);
      cnt("dark", 8'h01, 8'h00);
      check("active", {7'h00, active}, 8'h01);
      check("light", {7'h00, light}, 8'h01);
      bright <= 16'h0400;
      pulse(1);
      idle(15);
      cnt("hold", 8'h01, 8'h00);
      idle(30);
      cnt("end", 8'h01, 8'h01);
      pulse(1);
      idle(30);
      cnt("light", 8'h01, 8'h01);
      done("ceiling");
      mode(MDFB_APP_CEILING, 1'b1);
      pulse(1);
      idle(3);
      cnt("indep", 8'h02, 8'h01);
      idle(40);
      cnt("indep_end", 8'h02, 8'h02);
      mode(MDFB_APP_CEILING, 1'b0);
      twl <= 16'h0500;
      twl_wr <= 1'b1;
      @(posedge clk_sys_i) twl_wr <= 1'b0;
      pulse(1);
      idle(40);
      cnt("buswr", 8'h03, 8'h03);
      teach <= 1'b1;
      @(posedge clk_sys_i) teach <= 1'b0;
      pulse(1);
      idle(30);
      cnt("teach", 8'h03, 8'h03);
      done("twilight");
      cfg.eval_dly_en <= 1'b1;
      bright <= 16'h0080;
      pulse(1);
      idle(6);
      cnt("evd_early", 8'h03, 8'h03);
      idle(10);
      cnt("evd_late", 8'h04, 8'h03);
      idle(40);
      cfg.eval_dly_en <= 1'b0;
      done("eval delay");
      mode(MDFB_APP_PRESENCE, 1'b0);
      mot <= 1'b1;
      idle(3);
      cnt("pres", 8'h05, 8'h04);
      bright <= 16'h0800;
      idle(40);
      cnt("pres_off", 8'h05, 8'h05);
      mot <= 1'b0;
      idle(40);
      done("presence");
      mode(MDFB_APP_CEILING, 1'b0);
      man_on <= 1'b1;
      @(posedge clk_sys_i) man_on <= 1'b0;
      idle(3);
      cnt("man_on", 8'h06, 8'h05);
      man_off <= 1'b1;
      @(posedge clk_sys_i) man_off <= 1'b0;
      idle(3);
      cnt("man_off", 8'h06, 8'h06);
      done("manual");
      mode(MDFB_APP_ALERT, 1'b0);
      idle(1);
      check("out2_en", {7'h00, out2_en}, 8'h00);
      mot <= 1'b1;
      idle(6);
      mot <= 1'b0;
      pulse(2);
      idle(120);
      cnt("few", 8'h06, 8'h06);
      pulse(4);
      idle(3);
      cnt("alert", 8'h07, 8'h06);
      idle(15);
      pulse(1);
      idle(15);
      cnt("retrig", 8'h07, 8'h06);
      idle(30);
      cnt("alert_end", 8'h07, 8'h07);
      pulse(3);
      idle(5);
      cnt("cleared", 8'h07, 8'h07);
      pulse(1);
      idle(3);
      cnt("resume", 8'h08, 8'h07);
      idle(40);
      ext_en <= 1'b1;
      xpulse(4);
      idle(3);
      cnt("ext_alert", 8'h08, 8'h08);
      done("alert");
      mode(MDFB_APP_LIGHT_CTRL, 1'b0);
      xpulse(1);
      idle(3);
      cnt("lctrl", 8'h08, 8'h08);
      check("lctrl_out2", {7'h00, out2_en}, 8'h00);
      check("lctrl_presence", {7'h00, out1.presence}, 8'h01);
      check("fb2_out2", {7'h00, out2_en_b}, 8'h01);
      idle(40);
      done("light control");
      mode(MDFB_APP_PRESENCE, 1'b0);
      bright <= 16'h0080;
      pulse(1);
      idle(2);
      bright <= 16'h0800;
      cfg.off_dly_en <= 1'b1;
      idle(10);
      cnt("offdly", 8'h09, 8'h09);
      done("switch-off delay");
      results();
   end
endmodule : tb_mdfb_block

// file: verilog/mdfb_block.sv
// Operation
// - ceiling mode sends begin telegram on motion when brightness below twilight level
// - motion above twilight level sends no switch-on telegram
// - brightness-independent setting switches on for every motion, brightness ignored
// - twilight threshold from config, replaceable by teach capture or bus write
// - ceiling mode ignores brightness after begin telegram until detection ends
// - presence mode keeps evaluating brightness while light is on
// - above switch-off brightness stop motions, end after transmission or switch-off delay
// - end telegram after total delay of 10 s base plus additional delay
// - begin telegram optionally postponed by evaluation delay from detection start
// - light switchable on and off without motion: manual on and off inputs
// - alert mode always brightness-independent, twilight level ignored
// - alert motion recognised after configured impulse count within monitoring period
// - count reached sends begin message and starts transmission delay
// - each impulse during transmission delay restarts it from full value
// - transmission delay expiry without motion sends end message
// - too few impulses send nothing; next impulse after expiry opens new period
// - detection start clears monitoring; resumes on first impulse after delay expiry
// - alert mode standalone, extension inputs and outputs disabled
// - alert mode uses output 1 only, no teach, no evaluation delay
// - light control coupling disables own outputs and twilight evaluation
// - light control coupling only allowed on the first block instance
module mdfb_block #(
   parameter int BLOCK_INDEX = 1,
   parameter longint BASE_DELAY = mdfb_pkg::MDFB_BASE_DELAY_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire mdfb_pkg::mdfb_cfg_t cfg_i,
   input wire logic motion_i,
   input wire logic ext_motion_i,
   input wire logic ext_enable_i,
   input wire logic [mdfb_pkg::MDFB_BRIGHT_W-1:0] bright_i,
   input wire logic teach_i,
   input wire logic bus_twl_wr_i,
   input wire logic [mdfb_pkg::MDFB_BRIGHT_W-1:0] bus_twl_i,
   input wire logic manual_on_i,
   input wire logic manual_off_i,
   output mdfb_pkg::mdfb_out_t out1_o,
   output logic out2_en_o,
   output logic active_o
);
   import mdfb_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_EVAL = 4'b0010,
      S_DET = 4'b0100,
      S_HOLD = 4'b1000
   } mdfb_st_t;

   // ------------------------------------------------------------
   // derived modes
   // ------------------------------------------------------------
   logic is_alert;
   logic is_lc;
   logic indep;
   logic motion_any;
   logic [MDFB_TIME_W-1:0] full_dly;
   assign is_lc = (cfg_i.app == MDFB_APP_LIGHT_CTRL) && (BLOCK_INDEX == 1);
   assign is_alert = (cfg_i.app == MDFB_APP_ALERT);
   assign indep = cfg_i.bright_indep || is_alert || is_lc;
   assign motion_any = motion_i || (ext_motion_i && ext_enable_i && !is_alert);
   assign full_dly = MDFB_TIME_W'(BASE_DELAY) + cfg_i.add_dly;
   assign out2_en_o = !is_alert && !is_lc;

   // ------------------------------------------------------------
   // twilight level store
   // ------------------------------------------------------------
   logic [MDFB_BRIGHT_W-1:0] twl;
   logic twl_ovr;
   logic [MDFB_BRIGHT_W-1:0] next_twl;
   logic next_twl_ovr;
   always_comb
   begin
      next_twl = twl;
      next_twl_ovr = twl_ovr;
      if (bus_twl_wr_i)
      begin
         next_twl = bus_twl_i;
         next_twl_ovr = 1'b1;
      end
      else if (teach_i && !is_alert)
      begin
         next_twl = bright_i;
         next_twl_ovr = 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         twl <= '0;
         twl_ovr <= 1'b0;
      end
      else
      begin
         twl <= next_twl;
         twl_ovr <= next_twl_ovr;
      end
   end
   logic dark;
   assign dark = bright_i < (twl_ovr ? twl : cfg_i.twilight_cfg);

   // ------------------------------------------------------------
   // detection sequencer
   // ------------------------------------------------------------
   mdfb_st_t st, next_st;
   logic mot_d, next_mot_d;
   logic [MDFB_TIME_W-1:0] tmr, next_tmr;
   logic [MDFB_TIME_W-1:0] mon, next_mon;
   logic [MDFB_CNT_W-1:0] cnt, next_cnt;
   logic bright_off, next_bright_off;
   logic mon_run, next_mon_run;
   mdfb_out_t out_q, next_out;
   logic edge_m;
   logic alert_hit;
   logic go_on;
   assign edge_m = motion_any && !mot_d;
   assign alert_hit = edge_m && (cnt + 1'b1 >= cfg_i.alert_cnt);
   assign go_on = is_alert ? alert_hit : (edge_m && (indep || dark));

   always_comb
   begin
      next_st = st;
      next_mot_d = motion_any;
      next_tmr = tmr;
      next_mon = mon;
      next_cnt = cnt;
      next_bright_off = bright_off;
      next_mon_run = mon_run;
      next_out = '{begin_tg: 1'b0, end_tg: 1'b0, presence: out_q.presence};
      // alert monitoring window
      if (is_alert && st == S_IDLE && edge_m)
      begin
         if (!mon_run)
         begin
            next_mon_run = 1'b1;
            next_mon = cfg_i.monitor;
            next_cnt = MDFB_CNT_W'(1);
         end
         else
         begin
            next_cnt = cnt + 1'b1;
         end
      end
      else if (mon_run)
      begin
         if (mon == '0)
         begin
            next_mon_run = 1'b0;
            next_cnt = '0;
         end
         else
         begin
            next_mon = mon - 1'b1;
         end
      end
      case (st)
         S_IDLE:
         begin
            if (manual_on_i)
            begin
               next_st = S_DET;
               next_mon_run = 1'b0;
               next_cnt = '0;
               next_tmr = full_dly;
               next_out.begin_tg = 1'b1;
               next_out.presence = 1'b1;
            end
            else if (go_on)
            begin
               next_mon_run = 1'b0;
               next_cnt = '0;
               next_bright_off = 1'b0;
               if (cfg_i.eval_dly_en && !is_alert && !is_lc)
               begin
                  next_st = S_EVAL;
                  next_tmr = cfg_i.eval_dly;
               end
               else
               begin
                  next_st = S_DET;
                  next_tmr = full_dly;
                  next_out.begin_tg = 1'b1;
                  next_out.presence = 1'b1;
               end
            end
         end
         S_EVAL:
         begin
            if (tmr == '0)
            begin
               next_st = S_DET;
               next_tmr = full_dly;
               next_out.begin_tg = 1'b1;
               next_out.presence = 1'b1;
            end
            else
            begin
               next_tmr = tmr - 1'b1;
            end
         end
         S_DET:
         begin
            if (manual_off_i)
            begin
               next_st = S_IDLE;
               next_out.end_tg = 1'b1;
               next_out.presence = 1'b0;
            end
            else if (cfg_i.app == MDFB_APP_PRESENCE && !indep && bright_i > cfg_i.switch_off)
            begin
               next_st = S_HOLD;
               next_bright_off = 1'b1;
               next_tmr = cfg_i.off_dly_en ? cfg_i.off_dly : full_dly;
            end
            else if (edge_m || motion_any)
            begin
               next_tmr = full_dly;
            end
            else if (tmr == '0)
            begin
               next_st = S_IDLE;
               next_out.end_tg = 1'b1;
               next_out.presence = 1'b0;
            end
            else
            begin
               next_tmr = tmr - 1'b1;
            end
         end
         S_HOLD:
         begin
            // motions are no longer evaluated here
            if (tmr == '0 || manual_off_i)
            begin
               next_st = S_IDLE;
               next_bright_off = 1'b0;
               next_out.end_tg = 1'b1;
               next_out.presence = 1'b0;
            end
            else
            begin
               next_tmr = tmr - 1'b1;
            end
         end
         default:
         begin
            next_st = S_IDLE;
         end
      endcase
      if (is_lc)
      begin
         next_out.begin_tg = 1'b0;
         next_out.end_tg = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         st <= S_IDLE;
         mot_d <= 1'b0;
         tmr <= '0;
         mon <= '0;
         cnt <= '0;
         bright_off <= 1'b0;
         mon_run <= 1'b0;
         out_q <= '0;
      end
      else
      begin
         st <= next_st;
         mot_d <= next_mot_d;
         tmr <= next_tmr;
         mon <= next_mon;
         cnt <= next_cnt;
         bright_off <= next_bright_off;
         mon_run <= next_mon_run;
         out_q <= next_out;
      end
   end

   assign out1_o = out_q;
   assign active_o = (st != S_IDLE);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_bright_above_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (st == S_IDLE && edge_m && !indep && !dark && !manual_on_i) |=> !out_q.begin_tg)
      else $error("switch-on sent above twilight level");
   a_alert_begin_cnt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (st == S_IDLE && is_alert && alert_hit && !manual_on_i) |=> (out_q.begin_tg && st == S_DET))
      else $error("alert begin missing at count");
   a_retrig_full: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (st == S_DET && motion_any && !manual_off_i && cfg_i.app != MDFB_APP_PRESENCE) |=> tmr == full_dly)
      else $error("retrigger did not reload delay");
   a_end_on_expiry: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (st == S_DET && tmr == '0 && !motion_any && is_alert && !manual_off_i) |=> (out_q.end_tg && st == S_IDLE))
      else $error("end telegram missing");
   sequence s_alert_start;
      (st == S_IDLE && !out_q.begin_tg) ##1 (out_q.begin_tg && is_alert);
   endsequence : s_alert_start
   a_mon_cleared: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      s_alert_start |-> (!mon_run && cnt == '0))
      else $error("monitoring not cleared");
   a_lc_silent: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      is_lc |=> !(out_q.begin_tg || out_q.end_tg))
      else $error("coupled block sent telegram");
   // a held motion level must not add impulses while the window runs
   a_edge_once: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (st == S_IDLE && is_alert && mon_run && mon != '0 && !edge_m && !manual_on_i) |=> cnt == $past(cnt))
      else $error("impulse counted without new edge");
   a_eval_postpone: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (st == S_EVAL && tmr != '0) |=> !out_q.begin_tg)
      else $error("begin sent during evaluation delay");
endmodule : mdfb_block

// file: verilog/mdfb_pkg.sv
package mdfb_pkg;
   // ------------------------------------------------------------
   // applications
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MDFB_APP_CEILING = 2'h0,
      MDFB_APP_PRESENCE = 2'h1,
      MDFB_APP_ALERT = 2'h2,
      MDFB_APP_LIGHT_CTRL = 2'h3
   } mdfb_app_t;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int MDFB_CLK_HZ = 40000000;
   localparam int MDFB_BASE_DELAY_S = 10;
   localparam longint MDFB_BASE_DELAY_CYC = longint'(MDFB_BASE_DELAY_S) * longint'(MDFB_CLK_HZ);
   localparam int MDFB_TIME_W = 36;
   localparam int MDFB_CNT_W = 8;
   localparam int MDFB_BRIGHT_W = 16;
   localparam logic [7:0] MDFB_ALERT_CNT_DEF = 8'h04;

   // configuration, held stable by the owner
   typedef struct packed {
      mdfb_app_t app;
      logic bright_indep;
      logic [MDFB_BRIGHT_W-1:0] twilight_cfg;
      logic [MDFB_BRIGHT_W-1:0] switch_off;
      logic eval_dly_en;
      logic [MDFB_TIME_W-1:0] eval_dly;
      logic [MDFB_TIME_W-1:0] add_dly;
      logic off_dly_en;
      logic [MDFB_TIME_W-1:0] off_dly;
      logic [MDFB_CNT_W-1:0] alert_cnt;
      logic [MDFB_TIME_W-1:0] monitor;
   } mdfb_cfg_t;

   typedef struct packed {
      logic begin_tg;
      logic end_tg;
      logic presence;
   } mdfb_out_t;
endpackage : mdfb_pkg
